// ==== src/tp_pkg.sv ====
package tp_pkg;
  localparam int          PIN_COUNT     = 8;
  localparam int          SEL_WIDTH     = 3;
  localparam int          MCLK_MHZ      = 250;
  // Clock-debug frequencies in MHz, DBG7 in half-MHz units
  localparam int          DBG0_MHZ      = 60;
  localparam int          DBG1_MHZ      = 30;
  localparam int          DBG7_MHZ      = 15;  // 7.5 MHz held in half-MHz units
  // Half-period counts: toggle every N cycles
  localparam int          DBG0_HALF     = (MCLK_MHZ + DBG0_MHZ) / (2 * DBG0_MHZ);
  localparam int          DBG1_HALF     = MCLK_MHZ / (2 * DBG1_MHZ);
  localparam int          DBG7_HALF     = (MCLK_MHZ * 2) / (2 * DBG7_MHZ);
  localparam int          CNT_W         = 8;
  localparam logic [2:0]  SEL_QUIET     = 3'h0;
  localparam logic [2:0]  SEL_CLK_DEBUG = 3'h2;
  localparam logic [7:0]  DBG_LEVELS    = 8'h68;  // Pins 3,5,6 high, 4 low
  localparam logic [7:0]  ALL_OFF       = 8'h00;
  localparam logic [7:0]  ALL_ON        = 8'hFF;
  localparam logic [1:0]  SRC_DEFAULT   = 2'h0;
  localparam logic [1:0]  SRC_QUIET     = 2'h1;
  localparam logic [1:0]  SRC_CLKDBG    = 2'h2;
  localparam logic [1:0]  SRC_USER      = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  // Variable-rate clock on pin 2: half period from software, default
  localparam logic [CNT_W-1:0] VAR_HALF_DEF = 8'h06;
  // Pin 2 half-period limits: fastest near 20.8 MHz, slowest near 0.7 MHz
  localparam logic [CNT_W-1:0] VAR_HALF_MIN = 8'h06;
  localparam logic [CNT_W-1:0] VAR_HALF_MAX = 8'hB2;
endpackage

// ==== src/tp_div_if.sv ====
`timescale 1ns/100ps
interface tp_div_if;
  logic [tp_pkg::CNT_W-1:0] half;
  logic                     run;
  logic                     wave;
  modport owner (output half, output run, input wave);
  modport div (input half, input run, output wave);
endinterface

// ==== src/tp_clk_div.sv ====
`timescale 1ns/100ps
module tp_clk_div
  import tp_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  tp_div_if.div     ctl
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             wave_ff;
  logic             nxt_wave;

  // Square wave toggling every half counts while run
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_wave = wave_ff;
    if (!ctl.run)
    begin
      nxt_cnt  = CNT_ZERO;
      nxt_wave = 1'b0;
    end
    else if (cnt_ff + CNT_ONE >= ctl.half)
    begin
      nxt_cnt  = CNT_ZERO;
      nxt_wave = ~wave_ff;
    end
    else
    begin
      nxt_cnt = CNT_W'(cnt_ff + CNT_ONE);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_ff  <= CNT_ZERO;
      wave_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      wave_ff <= nxt_wave;
    end
  end

  assign ctl.wave = wave_ff;

  chk_div_stops: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    !ctl.run |=> !wave_ff)
    else $error("Divider wave not low when stopped");
endmodule

// ==== src/test_point_port.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Pins are inputs during reset; after release only clock debug or user mode drives them.
// - Pin state captured at release configures test mode until next reset.
// - Strap sampled each cycle during reset up to the low-to-high release; later changes ignored.
// - Pins read zero unless board pulls high; device has pulldowns.
// - Selection zero keeps all test point outputs in high impedance.
// - Selection 010 drives 60, 30, variable, H, L, H, H, 7.5 MHz.
// - Software may reselect test point outputs at any time from the second cycle after reset release.
module test_point_port
  import tp_pkg::*;
(
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [PIN_COUNT-1:0] test_point_bus_in,
  input  wire logic                 sw_sel_we_in,
  input  wire logic [1:0]           sw_sel_src_in,
  input  wire logic [PIN_COUNT-1:0] sw_user_data_in,
  input  wire logic [PIN_COUNT-1:0] sw_user_oe_in,
  input  wire logic [CNT_W-1:0]     sw_var_half_in,
  output logic      [PIN_COUNT-1:0] test_point_bus_out,
  output logic      [PIN_COUNT-1:0] test_point_bus_oe_out,
  output logic      [SEL_WIDTH-1:0] strap_select_bits_out
);
  logic [PIN_COUNT-1:0] sync1_ff;
  logic [PIN_COUNT-1:0] sync2_ff;
  logic                 in_rst_ff;
  logic [SEL_WIDTH-1:0] strap_ff;
  logic [SEL_WIDTH-1:0] nxt_strap;
  logic [1:0]           src_ff;
  logic [1:0]           nxt_src;
  logic [PIN_COUNT-1:0] user_d_ff;
  logic [PIN_COUNT-1:0] nxt_user_d;
  logic [PIN_COUNT-1:0] user_oe_ff;
  logic [PIN_COUNT-1:0] nxt_user_oe;
  logic [CNT_W-1:0]     var_half_ff;
  logic [CNT_W-1:0]     nxt_var_half;
  logic [PIN_COUNT-1:0] pin_ff;
  logic [PIN_COUNT-1:0] nxt_pin;
  logic [PIN_COUNT-1:0] oe_ff;
  logic [PIN_COUNT-1:0] nxt_oe;
  logic [1:0]           eff_src;
  logic [2:0]           dbg_wave;

  tp_div_if div_c [3] ();

  // One divider each for pins 0, 1, 7; pin 2 uses its own counter below
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_div
      tp_clk_div u_div (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ctl      (div_c[g])
      );
      assign dbg_wave[g] = div_c[g].wave;
      assign div_c[g].run = (eff_src == SRC_CLKDBG);
    end
  endgenerate

  assign div_c[0].half = CNT_W'(DBG0_HALF);
  assign div_c[1].half = CNT_W'(DBG1_HALF);
  assign div_c[2].half = CNT_W'(DBG7_HALF);

  logic [CNT_W-1:0] var_cnt_ff;
  logic [CNT_W-1:0] nxt_var_cnt;
  logic             var_wave_ff;
  logic             nxt_var_wave;

  // Default source follows strap; software may override
  always_comb
  begin
    eff_src = src_ff;
    if (src_ff == SRC_DEFAULT)
      eff_src = (strap_ff == SEL_CLK_DEBUG) ? SRC_CLKDBG : SRC_QUIET;
  end

  // Capture strap every cycle while in_rst_ff; last capture at the reset release edge
  always_comb
  begin
    nxt_strap = strap_ff;
    if (in_rst_ff)
      nxt_strap = sync2_ff[SEL_WIDTH-1:0];
  end

  // Software selection registers
  always_comb
  begin
    nxt_src      = src_ff;
    nxt_user_d   = user_d_ff;
    nxt_user_oe  = user_oe_ff;
    nxt_var_half = var_half_ff;
    if (sw_sel_we_in && !in_rst_ff)
    begin
      nxt_src      = sw_sel_src_in;
      nxt_user_d   = sw_user_data_in;
      nxt_user_oe  = sw_user_oe_in;
      if (sw_var_half_in < VAR_HALF_MIN)
        nxt_var_half = VAR_HALF_MIN;
      else if (sw_var_half_in > VAR_HALF_MAX)
        nxt_var_half = VAR_HALF_MAX;
      else
        nxt_var_half = sw_var_half_in;
    end
  end

  // Adjustable clock on pin 2
  always_comb
  begin
    nxt_var_cnt  = var_cnt_ff;
    nxt_var_wave = var_wave_ff;
    if (eff_src != SRC_CLKDBG)
    begin
      nxt_var_cnt  = CNT_ZERO;
      nxt_var_wave = 1'b0;
    end
    else if (var_cnt_ff + CNT_ONE >= var_half_ff)
    begin
      nxt_var_cnt  = CNT_ZERO;
      nxt_var_wave = ~var_wave_ff;
    end
    else
    begin
      nxt_var_cnt = CNT_W'(var_cnt_ff + CNT_ONE);
    end
  end

  // Output mux
  always_comb
  begin
    nxt_pin = ALL_OFF;
    nxt_oe  = ALL_OFF;
    case (eff_src)
      SRC_CLKDBG:
      begin
        nxt_pin    = DBG_LEVELS;
        nxt_pin[0] = dbg_wave[0];
        nxt_pin[1] = dbg_wave[1];
        nxt_pin[2] = var_wave_ff;
        nxt_pin[7] = dbg_wave[2];
        nxt_oe     = ALL_ON;
      end
      SRC_USER:
      begin
        nxt_pin = user_d_ff;
        nxt_oe  = user_oe_ff;
      end
      default:
      begin
        nxt_pin = ALL_OFF;
        nxt_oe  = ALL_OFF;
      end
    endcase
    if (in_rst_ff)
      nxt_oe = ALL_OFF;
  end

  always_ff @(posedge mclk_in)
  begin
    sync1_ff <= test_point_bus_in;
    sync2_ff <= sync1_ff;
    strap_ff <= nxt_strap;
    if (!rst_n_in)
    begin
      in_rst_ff   <= 1'b1;
      src_ff      <= SRC_DEFAULT;
      user_d_ff   <= ALL_OFF;
      user_oe_ff  <= ALL_OFF;
      var_half_ff <= VAR_HALF_DEF;
      var_cnt_ff  <= CNT_ZERO;
      var_wave_ff <= 1'b0;
      pin_ff      <= ALL_OFF;
      oe_ff       <= ALL_OFF;
    end
    else
    begin
      in_rst_ff   <= 1'b0;
      src_ff      <= nxt_src;
      user_d_ff   <= nxt_user_d;
      user_oe_ff  <= nxt_user_oe;
      var_half_ff <= nxt_var_half;
      var_cnt_ff  <= nxt_var_cnt;
      var_wave_ff <= nxt_var_wave;
      pin_ff      <= nxt_pin;
      oe_ff       <= nxt_oe;
    end
  end

  assign test_point_bus_out    = pin_ff;
  assign test_point_bus_oe_out = oe_ff;
  assign strap_select_bits_out = strap_ff;

  sequence s_release;
    $rose(rst_n_in);
  endsequence

  sequence s_debug_after_release;
    s_release ##1 (eff_src == SRC_CLKDBG);
  endsequence

  chk_reset_tristate: assert property (@(posedge mclk_in)
    !rst_n_in |=> oe_ff == ALL_OFF)
    else $error("Pins driven during reset");
  chk_strap_capture: assert property (@(posedge mclk_in)
    s_release |=> strap_ff == $past(sync2_ff[SEL_WIDTH-1:0]))
    else $error("Strap not captured at release");
  chk_strap_hold: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) !in_rst_ff |=> $stable(strap_ff))
    else $error("Strap changed after release");
  chk_quiet_hiz: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (src_ff == SRC_DEFAULT && strap_ff == SEL_QUIET) |=> oe_ff == ALL_OFF)
    else $error("Quiet mode drives pins");
  chk_dbg_levels: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (eff_src == SRC_CLKDBG && !in_rst_ff) |=>
      (pin_ff[6:3] == DBG_LEVELS[6:3] && oe_ff == ALL_ON))
    else $error("Clock debug levels wrong");
  chk_var_range: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (var_half_ff >= VAR_HALF_MIN && var_half_ff <= VAR_HALF_MAX))
    else $error("Pin 2 half period out of range");
  chk_user_route: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (src_ff == SRC_USER) |=> oe_ff == $past(user_oe_ff))
    else $error("User selection not routed");
  chk_override_reset: assert property (@(posedge mclk_in)
    !rst_n_in |=> src_ff == SRC_DEFAULT)
    else $error("Override survived reset");
  chk_early_write: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    in_rst_ff |=> src_ff == SRC_DEFAULT)
    else $error("Selection taken in first cycle after reset");
  chk_release_drive: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    s_debug_after_release |->
      (oe_ff == ALL_OFF) ##1 (oe_ff == ALL_ON))
    else $error("Pins not driven after release");
endmodule

// ==== verif/tp_board.sv ====
`timescale 1ns/100ps
module tp_board
  import tp_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] drv_in,
  input  wire logic [PIN_COUNT-1:0] oe_in,
  input  wire logic [SEL_WIDTH-1:0] jumper_in,
  output logic      [PIN_COUNT-1:0] pin_out
);
  logic [PIN_COUNT-1:0] idle;
  // Upper five pins left open, jumpers only on the lower three
  assign idle = {5'h00, jumper_in};
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
      pin_out[i] = oe_in[i] ? drv_in[i] : idle[i];
  end
endmodule

// ==== verif/reset_strapped_test_point_port_tb.sv ====
`timescale 1ns/100ps
module reset_strapped_test_point_port_tb
  import tp_pkg::*;
;
  logic                 mclk_in = 1'b0;
  logic                 rst_n_in = 1'b0;
  logic [PIN_COUNT-1:0] pins;
  logic                 we = 1'b0;
  logic [1:0]           src = 2'h0;
  logic [PIN_COUNT-1:0] udata = 8'h00;
  logic [PIN_COUNT-1:0] uoe = 8'h00;
  logic [CNT_W-1:0]     vhalf = 8'h08;
  logic [SEL_WIDTH-1:0] jumper = 3'h0;
  logic [PIN_COUNT-1:0] q;
  logic [PIN_COUNT-1:0] oe;
  logic [SEL_WIDTH-1:0] sel;
  int                   n_fail = 0;
  int                   samples_checked = 0;

  always #2 mclk_in = ~mclk_in;

  test_point_port i_dut (
    .mclk_in              (mclk_in),
    .rst_n_in             (rst_n_in),
    .test_point_bus_in    (pins),
    .sw_sel_we_in         (we),
    .sw_sel_src_in        (src),
    .sw_user_data_in      (udata),
    .sw_user_oe_in        (uoe),
    .sw_var_half_in       (vhalf),
    .test_point_bus_out   (q),
    .test_point_bus_oe_out(oe),
    .strap_select_bits_out(sel)
  );

  tp_board i_board (
    .drv_in   (q),
    .oe_in    (oe),
    .jumper_in(jumper),
    .pin_out  (pins)
  );

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic do_reset(input logic [2:0] strap);
    @(negedge mclk_in);
    rst_n_in = 1'b0;
    jumper = strap;
    repeat (3) @(negedge mclk_in);
    chk("oe in reset", oe, ALL_OFF);
    rst_n_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk("strap", {5'h00, sel}, {5'h00, strap});
  endtask

  task automatic sw_write(input logic [1:0] s, input logic [7:0] d,
                          input logic [7:0] e);
    src = s;
    udata = d;
    uoe = e;
    we = 1'b1;
    @(negedge mclk_in);
    we = 1'b0;
    repeat (2) @(negedge mclk_in);
  endtask

  task automatic toggles(input int b, input int win, input int exp);
    int   n;
    logic last;
    n = 0;
    last = q[b];
    repeat (win)
    begin
      @(negedge mclk_in);
      if (q[b] !== last)
        n++;
      last = q[b];
    end
    chk("toggle count", n[7:0], exp[7:0]);
  endtask

  task automatic quiet_default();
    do_reset(SEL_QUIET);
    chk("quiet oe", oe, ALL_OFF);
    jumper = SEL_CLK_DEBUG;
    repeat (8) @(negedge mclk_in);
    chk("late strap", {5'h00, sel}, {5'h00, SEL_QUIET});
    chk("late oe", oe, ALL_OFF);
  endtask

  task automatic clock_debug();
    do_reset(SEL_CLK_DEBUG);
    chk("debug oe", oe, ALL_ON);
    chk("levels", q & 8'h78, DBG_LEVELS);
    jumper = SEL_QUIET;
    toggles(0, 64, 64 / DBG0_HALF);
    toggles(1, 64, 64 / DBG1_HALF);
    toggles(7, 64, 64 / DBG7_HALF);
    toggles(2, VAR_HALF_DEF * 8, 8);
    chk("strap held", {5'h00, sel}, {5'h00, SEL_CLK_DEBUG});
  endtask

  task automatic override();
    sw_write(SRC_USER, 8'hA5, 8'hF0);
    chk("user oe", oe, 8'hF0);
    chk("user data", q & 8'hF0, 8'hA0);
    sw_write(SRC_QUIET, 8'h00, 8'h00);
    chk("sw quiet", oe, ALL_OFF);
    sw_write(SRC_CLKDBG, 8'h00, 8'h00);
    chk("sw debug", oe, ALL_ON);
    toggles(2, 64, 64 / 8);
    vhalf = 8'h01;
    sw_write(SRC_CLKDBG, 8'h00, 8'h00);
    toggles(2, VAR_HALF_MIN * 8, 8);
    vhalf = 8'h08;
    sw_write(SRC_QUIET, 8'h00, 8'h00);
    do_reset(SEL_CLK_DEBUG);
    chk("restored", oe, ALL_ON);
  endtask

  task automatic close_out();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    quiet_default();
    clock_debug();
    override();
    close_out();
  end
endmodule
